// ---- logic/mrm_pkg.sv ----
// constants, register map and carrier types of the memory map block
package mrm_pkg;
   // bus side: cpu byte n sits at word n, plus two words of our own
   localparam int ADDR_W = 19;
   localparam logic [18:0] ADDR_STATUS = 19'h4_0000;
   localparam logic [18:0] ADDR_CTRL = 19'h4_0004;
   localparam int STAT_RSV_BIT = 0;
   localparam int STAT_STK_BIT = 1;
   localparam int CTRL_FWE_BIT = 0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // cpu address space
   localparam logic [15:0] REG_LAST = 16'h007F;
   localparam logic [15:0] RAM_LAST = 16'h00FF;
   localparam logic [15:0] STK_BASE = 16'h00C0;
   localparam logic [15:0] STK_LAST = 16'h00FF;
   localparam logic [15:0] CAL_BASE = 16'hDEE0;
   localparam logic [15:0] CAL_LAST = 16'hDEE3;
   localparam logic [15:0] FLASH_BASE = 16'hFC00;
   localparam int RAM_BYTES = 128;
   localparam int FLASH_BYTES = 1024;
   // register page indices
   localparam logic [6:0] IDX_PA_DATA = 7'h00;
   localparam logic [6:0] IDX_PA_DIR = 7'h01;
   localparam logic [6:0] IDX_PA_OPT = 7'h02;
   localparam logic [6:0] IDX_LT_CTRL = 7'h0B;
   localparam logic [6:0] IDX_LT_CAP = 7'h0C;
   localparam logic [6:0] IDX_AT_CTRL = 7'h0D;
   localparam logic [6:0] IDX_CNT_HIGH = 7'h0E;
   localparam logic [6:0] IDX_CNT_LOW = 7'h0F;
   localparam logic [6:0] IDX_RLD_HIGH = 7'h10;
   localparam logic [6:0] IDX_RLD_LOW = 7'h11;
   localparam logic [6:0] IDX_PWM_CTRL = 7'h12;
   localparam logic [6:0] IDX_PWM0_CTRL = 7'h13;
   localparam logic [6:0] IDX_DUTY_HIGH = 7'h17;
   localparam logic [6:0] IDX_DUTY_LOW = 7'h18;
   localparam logic [6:0] IDX_PROG_CTRL = 7'h2F;
   localparam logic [6:0] IDX_NVM_CTRL = 7'h30;
   localparam logic [6:0] IDX_CONV_CTRL = 7'h34;
   localparam logic [6:0] IDX_CONV_HIGH = 7'h35;
   localparam logic [6:0] IDX_CONV_LOW = 7'h36;
   localparam logic [6:0] IDX_EIRQ1 = 7'h37;
   localparam logic [6:0] IDX_MCLK_CTRL = 7'h38;
   localparam logic [6:0] IDX_OSC_TRIM = 7'h39;
   localparam logic [6:0] IDX_SYS_INT = 7'h3A;
   localparam logic [6:0] IDX_EIRQ2 = 7'h3D;
   localparam logic [6:0] IDX_SUPPLY_THR = 7'h3E;
   localparam logic [6:0] IDX_CLK_SRC = 7'h3F;
   localparam logic [6:0] IDX_MUX_FIRST = 7'h47;
   localparam logic [6:0] IDX_MUX_SECOND = 7'h48;
   // reset values; undefined bits come up as zero
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_PA_DIR = 8'h08;
   localparam logic [7:0] RST_PA_OPT = 8'h02;
   localparam logic [7:0] RST_OSC_TRIM = 8'hFF;
   localparam logic [7:0] RST_SYS_INT = 8'h00;
   localparam logic [7:0] RST_CONV_HIGH = 8'h00;
   localparam logic [7:0] RST_SUPPLY_THR = 8'h03;
   localparam logic [7:0] RST_CLK_SRC = 8'h09;
   typedef enum logic [4:0] {
      RG_REG = 5'b00001, RG_RAM = 5'b00010, RG_CAL = 5'b00100,
      RG_FLASH = 5'b01000, RG_RSV = 5'b10000} mrm_region_t;
   typedef enum logic [2:0] {
      SP_CPU = 3'b001, SP_OWN = 3'b010, SP_BAD = 3'b100} mrm_space_t;
   typedef enum logic [2:0] {
      K_RSV = 3'b001, K_RW = 3'b010, K_RO = 3'b100} mrm_kind_t;
   typedef enum logic [1:0] {WS_COLLECT = 2'b01, WS_RESP = 2'b10} mrm_wstate_t;
   // values the peripherals present in read-only locations
   typedef struct packed {
      logic [7:0] lite_timer_capture_value;
      logic [7:0] reload_counter_high;
      logic [7:0] converter_result_high;
   } mrm_periph_t;
   // software settings handed to the peripherals
   typedef struct packed {
      logic [7:0] port_a_data_reg;
      logic [7:0] port_a_direction_reg;
      logic [7:0] port_a_option_reg;
      logic [7:0] oscillator_trim;
      logic [7:0] system_integrity_ctrl_status;
      logic [7:0] supply_monitor_threshold;
      logic [7:0] clock_source_ctrl_status;
      logic [7:0] pin_reset_mux_ctrl_first;
      logic [7:0] pin_reset_mux_ctrl_second;
   } mrm_cfg_t;
endpackage

// ---- logic/mrm_memory_map.sv ----
// address decoder, register page, ram and program memory behind axi4-lite
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module mrm_memory_map
   import mrm_pkg::*;
#(
   parameter int RAM_DEPTH = RAM_BYTES,
   parameter int FLASH_DEPTH = FLASH_BYTES
)(
   input wire logic mclk, // 125 MHz system clock
   input wire logic reset, // synchronous, active high
   input wire logic [ADDR_W-1:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte strobes, lane 0 used
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [ADDR_W-1:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic [7:0] pa_pin_in, // live port a pin levels
   output logic [7:0] pa_oe_n_q, // port a enable, low drives pin
   input wire mrm_periph_t periph_in, // read-only peripheral values
   input wire logic [31:0] cal_values, // calibration bytes, DEE0h in low byte
   input wire logic user_mode, // high in user mode
   input wire logic [1:0] opt_sector0_sel, // option byte sector 0 size code
   output mrm_cfg_t cfg_q, // register settings to peripherals
   output logic stack_hit_q // one cycle after a stack access
);
   localparam int RAM_AW = $clog2(RAM_DEPTH);
   localparam int FLASH_AW = $clog2(FLASH_DEPTH);

   logic [7:0] page_q [0:127];
   logic [7:0] ram_q [0:RAM_DEPTH-1];
   logic [7:0] flash_q [0:FLASH_DEPTH-1];
   mrm_wstate_t wst_q;
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic aw_got_q, w_got_q;
   logic [ADDR_W-1:0] waddr_q;
   logic [7:0] wbyte_q;
   logic wlane_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [1:0] status_q;
   logic fwe_q;
   logic [1:0] opt_q;
   logic wr_fire, ar_hs;
   logic [15:0] wcpu, rcpu;
   mrm_space_t wsp, rsp;
   mrm_region_t wreg, rreg;
   logic wr_rsv, wr_stk, rd_rsv, rd_stk;
   logic [7:0] rd_byte;
   logic [31:0] rd_word;

   // which part of the bus space an address falls in
   function automatic mrm_space_t space_of(input logic [ADDR_W-1:0] a);
      if (a[18] == 1'b0)
      begin
         return SP_CPU;
      end
      if (a[18:2] == ADDR_STATUS[18:2] || a[18:2] == ADDR_CTRL[18:2])
      begin
         return SP_OWN;
      end
      return SP_BAD;
   endfunction

   // cpu memory map decode
   function automatic mrm_region_t region_of(input logic [15:0] a);
      if (a <= REG_LAST)
      begin
         return RG_REG;
      end
      if (a <= RAM_LAST)
      begin
         return RG_RAM;
      end
      if (a >= CAL_BASE && a <= CAL_LAST)
      begin
         return RG_CAL;
      end
      if (a >= FLASH_BASE)
      begin
         return RG_FLASH;
      end
      return RG_RSV;
   endfunction

   // access type of each register page location
   function automatic mrm_kind_t kind_of(input logic [6:0] i);
      case (i)
         IDX_LT_CAP, IDX_CNT_HIGH, IDX_CONV_HIGH: return K_RO;
         IDX_PA_DATA, IDX_PA_DIR, IDX_PA_OPT, IDX_LT_CTRL, IDX_AT_CTRL,
         IDX_CNT_LOW, IDX_RLD_HIGH, IDX_RLD_LOW, IDX_PWM_CTRL,
         IDX_PWM0_CTRL, IDX_DUTY_HIGH, IDX_DUTY_LOW, IDX_PROG_CTRL,
         IDX_NVM_CTRL, IDX_CONV_CTRL, IDX_CONV_LOW, IDX_EIRQ1,
         IDX_MCLK_CTRL, IDX_OSC_TRIM, IDX_SYS_INT, IDX_EIRQ2,
         IDX_SUPPLY_THR, IDX_CLK_SRC, IDX_MUX_FIRST, IDX_MUX_SECOND: return K_RW;
         default: return K_RSV;
      endcase
   endfunction

   // reset value of each register page location
   function automatic logic [7:0] reset_of(input logic [6:0] i);
      case (i)
         IDX_PA_DIR: return RST_PA_DIR;
         IDX_PA_OPT: return RST_PA_OPT;
         IDX_OSC_TRIM: return RST_OSC_TRIM;
         IDX_SYS_INT: return RST_SYS_INT;
         IDX_CONV_HIGH: return RST_CONV_HIGH;
         IDX_SUPPLY_THR: return RST_SUPPLY_THR;
         IDX_CLK_SRC: return RST_CLK_SRC;
         default: return RST_ZERO;
      endcase
   endfunction

   // offsets at or above the boundary belong to sector 0
   function automatic logic in_sector0(input logic [15:0] a, input logic [1:0] sel);
      return a[9:8] >= (2'd3 - sel);
   endfunction

   function automatic logic in_stack(input logic [15:0] a);
      return a >= STK_BASE && a <= STK_LAST;
   endfunction

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   // settings out, straight from the page flops
   assign cfg_q.port_a_data_reg = page_q[IDX_PA_DATA];
   assign cfg_q.port_a_direction_reg = page_q[IDX_PA_DIR];
   assign cfg_q.port_a_option_reg = page_q[IDX_PA_OPT];
   assign cfg_q.oscillator_trim = page_q[IDX_OSC_TRIM];
   assign cfg_q.system_integrity_ctrl_status = page_q[IDX_SYS_INT];
   assign cfg_q.supply_monitor_threshold = page_q[IDX_SUPPLY_THR];
   assign cfg_q.clock_source_ctrl_status = page_q[IDX_CLK_SRC];
   assign cfg_q.pin_reset_mux_ctrl_first = page_q[IDX_MUX_FIRST];
   assign cfg_q.pin_reset_mux_ctrl_second = page_q[IDX_MUX_SECOND];

   // write side decode; the write commits once address and data are both held
   always_comb
   begin
      wr_fire = (wst_q == WS_COLLECT) && aw_got_q && w_got_q;
      wcpu = waddr_q[17:2];
      wsp = space_of(waddr_q);
      wreg = region_of(wcpu);
      wr_rsv = (wsp == SP_CPU) && ((wreg == RG_RSV) ||
         (wreg == RG_REG && kind_of(wcpu[6:0]) == K_RSV));
      wr_stk = (wsp == SP_CPU) && in_stack(wcpu);
   end

   // write channel handshake; address and data may arrive in either order
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         wst_q <= WS_COLLECT;
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         waddr_q <= '0;
         wbyte_q <= RST_ZERO;
         wlane_q <= 1'b0;
      end
      else
      begin
         unique case (wst_q)
            WS_COLLECT:
            begin
               if (awvalid && awready_q)
               begin
                  waddr_q <= awaddr;
                  aw_got_q <= 1'b1;
                  awready_q <= 1'b0;
               end
               if (wvalid && wready_q)
               begin
                  wbyte_q <= wdata[7:0];
                  wlane_q <= wstrb[0];
                  w_got_q <= 1'b1;
                  wready_q <= 1'b0;
               end
               if (wr_fire)
               begin
                  aw_got_q <= 1'b0;
                  w_got_q <= 1'b0;
                  bvalid_q <= 1'b1;
                  bresp_q <= (wsp == SP_BAD) ? RESP_DECERR : RESP_OKAY;
                  wst_q <= WS_RESP;
               end
            end
            WS_RESP:
            begin
               if (bready)
               begin
                  bvalid_q <= 1'b0;
                  awready_q <= 1'b1;
                  wready_q <= 1'b1;
                  wst_q <= WS_COLLECT;
               end
            end
         endcase
      end
   end

   // register page; read-only slots follow the peripherals every cycle
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         for (int i = 0; i < 128; i++)
         begin
            page_q[i] <= reset_of(7'(i));
         end
         pa_oe_n_q <= ~RST_PA_DIR;
      end
      else
      begin
         page_q[IDX_LT_CAP] <= periph_in.lite_timer_capture_value;
         page_q[IDX_CNT_HIGH] <= periph_in.reload_counter_high;
         page_q[IDX_CONV_HIGH] <= periph_in.converter_result_high;
         // read-only and reserved slots never take bus data
         if (wr_fire && wlane_q && wsp == SP_CPU && wreg == RG_REG &&
            kind_of(wcpu[6:0]) == K_RW)
         begin
            page_q[wcpu[6:0]] <= wbyte_q;
            if (wcpu[6:0] == IDX_PA_DIR)
            begin
               pa_oe_n_q <= ~wbyte_q;
            end
         end
      end
   end

   // ram, no reset; contents are undefined at power up
   always_ff @(posedge mclk)
   begin
      if (wr_fire && wlane_q && wsp == SP_CPU && wreg == RG_RAM)
      begin
         ram_q[wcpu[RAM_AW-1:0]] <= wbyte_q;
      end
   end

   // program memory: only sector 1 takes writes, and only when enabled,
   // so the vectors in sector 0 cannot be lost by a runaway program
   always_ff @(posedge mclk)
   begin
      if (wr_fire && wlane_q && wsp == SP_CPU && wreg == RG_FLASH && fwe_q &&
         !in_sector0(wcpu, opt_q))
      begin
         flash_q[wcpu[FLASH_AW-1:0]] <= wbyte_q;
      end
   end

   // read data mux; reserved reads give zero
   always_comb
   begin
      rcpu = araddr[17:2];
      rsp = space_of(araddr);
      rreg = region_of(rcpu);
      rd_byte = RST_ZERO;
      rd_rsv = 1'b0;
      rd_stk = (rsp == SP_CPU) && in_stack(rcpu);
      unique case (rreg)
         RG_REG:
         begin
            if (kind_of(rcpu[6:0]) == K_RSV)
            begin
               rd_rsv = 1'b1;
            end
            else if (rcpu[6:0] == IDX_PA_DATA)
            begin
               rd_byte = (page_q[IDX_PA_DATA] & page_q[IDX_PA_DIR]) |
                  (pa_pin_in & ~page_q[IDX_PA_DIR]);
            end
            else
            begin
               rd_byte = page_q[rcpu[6:0]];
            end
         end
         RG_RAM: rd_byte = ram_q[rcpu[RAM_AW-1:0]];
         // fed from a dedicated input, so an erase never takes it away
         RG_CAL: rd_byte = user_mode ? cal_values[8*rcpu[1:0] +: 8] : RST_ZERO;
         RG_FLASH: rd_byte = flash_q[rcpu[FLASH_AW-1:0]];
         RG_RSV: rd_rsv = 1'b1;
      endcase
      rd_word = {24'h0000_00, rd_byte};
      if (rsp == SP_OWN)
      begin
         rd_rsv = 1'b0;
         if (araddr[18:2] == ADDR_STATUS[18:2])
         begin
            rd_word = {30'h0000_0000, status_q};
         end
         else
         begin
            rd_word = {31'h0000_0000, fwe_q};
         end
      end
      else if (rsp == SP_BAD)
      begin
         rd_rsv = 1'b0;
         rd_word = 32'h0000_0000;
      end
   end

   // read channel: answer in the cycle after the address is taken
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= (rsp == SP_BAD) ? RESP_DECERR : RESP_OKAY;
      end
      else if (rvalid_q && rready)
      begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   assign ar_hs = arvalid && arready_q;

   // sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         status_q <= 2'b00;
         fwe_q <= 1'b0;
         stack_hit_q <= 1'b0;
      end
      else
      begin
         stack_hit_q <= (ar_hs && rd_stk) || (wr_fire && wr_stk);
         if (wr_fire && wlane_q && wsp == SP_OWN)
         begin
            if (waddr_q[18:2] == ADDR_CTRL[18:2])
            begin
               fwe_q <= wbyte_q[CTRL_FWE_BIT];
            end
         end
         status_q <= (status_q & ~((wr_fire && wlane_q && wsp == SP_OWN &&
            waddr_q[18:2] == ADDR_STATUS[18:2]) ? wbyte_q[1:0] : 2'b00)) |
            {stack_hit_q, (ar_hs && rd_rsv) || (wr_fire && wr_rsv)};
      end
   end

   // option byte is taken while reset is held and kept afterwards
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         opt_q <= opt_sector0_sel;
      end
   end
endmodule
`default_nettype wire

// ---- tb/mrm_memory_map_chk_sva.sv ----
// concurrent checks on the memory map block's bus and register outputs
`timescale 1ns/100ps
`default_nettype none
module mrm_memory_map_chk
   import mrm_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic reset, // synchronous reset
   input wire logic awvalid, // write address valid
   input wire logic awready, // write address ready
   input wire logic wvalid, // write data valid
   input wire logic wready, // write data ready
   input wire logic [1:0] bresp, // write response
   input wire logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [ADDR_W-1:0] araddr, // read address
   input wire logic arvalid, // read address valid
   input wire logic arready, // read address ready
   input wire logic [31:0] rdata, // read data
   input wire logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic [7:0] pa_oe_n_q, // port a enables
   input wire mrm_cfg_t cfg_q, // register settings
   input wire logic stack_hit_q // stack access pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   // handshakes as seen at a sampling edge
   sequence s_ar_taken;
      arvalid && arready;
   endsequence
   sequence s_both_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   a_read_answer: assert property (s_ar_taken |=> rvalid && !arready)
      else $error("read answer not one cycle after address");
   a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped before taken");
   a_write_answer: assert property (s_both_taken |=> !bvalid ##1 bvalid)
      else $error("write response not two cycles after handshake");
   a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");
   a_write_single: assert property (bvalid |-> !awready && !wready)
      else $error("new write accepted while response pending");
   a_upper_zero: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
      else $error("upper read lanes not zero");
   // reserved page slots from 03h to 46h must read back as zero whatever was written there
   a_rsv_zero: assert property (s_ar_taken ##0 (!araddr[18] && araddr[17:2] inside
      {[16'h0003:16'h000A], [16'h0014:16'h0016], [16'h0019:16'h002E],
      [16'h0031:16'h0033], [16'h003B:16'h003C], [16'h0040:16'h0046]}) |=> rdata == 0)
      else $error("reserved page slot read not zero");
   a_stack_flag: assert property (s_ar_taken ##0 (!araddr[18] &&
      araddr[17:2] inside {[16'h00C0:16'h00FF]}) |=> stack_hit_q)
      else $error("stack access not flagged");
   // enables load on the same edge as the direction flop; the check still waits for two stable samples
   a_oe_dir: assert property ($stable(cfg_q.port_a_direction_reg)[*2] |->
      pa_oe_n_q == ~cfg_q.port_a_direction_reg)
      else $error("port enables do not follow direction");
   a_reset_vals: assert property (disable iff (1'b0) reset |=> pa_oe_n_q == 8'hF7 &&
      cfg_q.oscillator_trim == 8'hFF && cfg_q.clock_source_ctrl_status == 8'h09 &&
      cfg_q.supply_monitor_threshold == 8'h03 && !bvalid && !rvalid)
      else $error("outputs not at reset values");
endmodule
bind mrm_memory_map mrm_memory_map_chk chk_u (.mclk, .reset, .awvalid, .awready, .wvalid,
   .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready,
   .pa_oe_n_q, .cfg_q, .stack_hit_q);
`default_nettype wire

// ---- tb/mrm_periph_model.sv ----
// far side of the block: port a pins, peripheral values and calibration bytes
`timescale 1ns/100ps
`default_nettype none
module mrm_periph_model
   import mrm_pkg::*;
(
   input wire logic [7:0] pa_oe_n_q, // device port enables
   input wire mrm_cfg_t cfg_q, // device register settings
   input wire logic [7:0] ext_pins, // levels the board puts on pins
   output logic [7:0] pa_pin_in, // resolved pin levels
   output mrm_periph_t periph_in, // read-only values
   output logic [31:0] cal_values // calibration bytes
);
   // a pin follows the device where it drives, the board elsewhere
   assign pa_pin_in = (~pa_oe_n_q & cfg_q.port_a_data_reg) | (pa_oe_n_q & ext_pins);
   // timers idle at zero, converter holds a finished sample
   assign periph_in = {8'h00, 8'h00, 8'h33};
   // fixed silicon values, so no erase can reach them
   assign cal_values = 32'hC3C2_C1C0;
endmodule
`default_nettype wire

// ---- tb/mrm_memory_map_test.sv ----
// self-checking bench for the memory map block
`timescale 1ns/100ps
`default_nettype none
module mrm_memory_map_test
   import mrm_pkg::*;
;
   logic mclk = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic user_mode = 0, awready, wready, bvalid, arready, rvalid, stack_hit_q;
   logic [18:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, cal_values;
   logic [3:0] wstrb = '0;
   logic [1:0] opt_sector0_sel = '0, bresp, rresp;
   logic [7:0] ext_pins = 8'h3C, pa_pin_in, pa_oe_n_q;
   mrm_periph_t periph_in;
   mrm_cfg_t cfg_q;
   int err_count = 0, checks_done = 0;
   localparam logic [15:0] RV_ADR [12] = '{16'h0000, 16'h0001, 16'h0002, 16'h000D, 16'h000F,
      16'h0010, 16'h0039, 16'h003A, 16'h003E, 16'h003F, 16'h0047, 16'h0048};
   // a data read shows the board's 3Ch on input bits; bit 3 drives the 00h latch
   localparam logic [7:0] RV_VAL [12] = '{8'h34, 8'h08, 8'h02, 8'h00, 8'h00, 8'h00, 8'hFF,
      8'h00, 8'h03, 8'h09, 8'h00, 8'h00};
   localparam logic [15:0] RSV_ADR [5] = '{16'h0003, 16'h0014, 16'h002E, 16'h0040, 16'h1234};
   mrm_memory_map dut_u (.mclk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .pa_pin_in, .pa_oe_n_q, .periph_in, .cal_values, .user_mode, .opt_sector0_sel,
      .cfg_q, .stack_hit_q);
   mrm_periph_model far_u (.pa_oe_n_q, .cfg_q, .ext_pins, .pa_pin_in, .periph_in, .cal_values);
   // 125 MHz system clock
   initial
   begin
      forever #4 mclk = ~mclk;
   end
   function automatic logic [18:0] ca(input logic [15:0] a);
      return {1'b0, a, 2'b00};
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask
   // address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [18:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= 4'h1;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while (!bvalid && n < 40);
      bready <= 1'b0;
      chk("write response", {29'h0, 1'b1, RESP_OKAY}, {29'h0, bvalid, bresp});
   endtask
   task automatic axi_rd(input logic [18:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (arready) arvalid <= 1'b0;
      end
      while (!rvalid && n < 40);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      chk("read answered", 32'h0000_0001, {31'h0, rvalid});
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(ca(a), d, r);
      chk(nm, {24'h00_0000, e}, d);
      chk("read response", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask
   task automatic t_reset_values;
      for (int i = 0; i < 12; i++) rd_chk(RV_ADR[i], RV_VAL[i], "reset value");
      chk("data latch reset", 32'h0000_0000, {24'h0, cfg_q.port_a_data_reg});
   endtask
   // inverted reset pattern proves every bit is writable
   task automatic t_rw_regs;
      for (int i = 3; i < 12; i++)
      begin
         axi_wr(ca(RV_ADR[i]), ~RV_VAL[i]);
         rd_chk(RV_ADR[i], ~RV_VAL[i], "register readback");
      end
      chk("trim output", 32'h0000_0000, {24'h0, cfg_q.oscillator_trim});
   endtask
   task automatic t_read_only;
      axi_wr(ca(16'h000C), 8'hA5);
      rd_chk(16'h000C, 8'h00, "capture value");
      axi_wr(ca(16'h000E), 8'h5A);
      rd_chk(16'h000E, 8'h00, "counter high");
      axi_wr(ca(16'h0035), 8'hC3);
      rd_chk(16'h0035, 8'h33, "converter high");
   endtask
   // low nibble driven, high nibble from the board
   task automatic t_port;
      axi_wr(ca(16'h0001), 8'h0F);
      axi_wr(ca(16'h0000), 8'h25); // bits 4 to 7 are inputs, so the read shows the board there
      rd_chk(16'h0000, 8'h35, "port data");
      chk("port enables", 32'h0000_00F0, {24'h0, pa_oe_n_q});
      ext_pins <= 8'hC3;
      rd_chk(16'h0000, 8'hC5, "port data live");
   endtask
   task automatic t_reserved;
      logic [31:0] d;
      logic [1:0] r;
      for (int i = 0; i < 5; i++)
      begin
         axi_wr(ca(RSV_ADR[i]), 8'hFF);
         rd_chk(RSV_ADR[i], 8'h00, "reserved slot");
      end
      axi_rd(19'h4_0008, d, r);
      chk("unmapped response", {30'h0, RESP_DECERR}, {30'h0, r});
   endtask
   task automatic t_cal;
      user_mode <= 1'b1;
      for (int i = 0; i < 4; i++) rd_chk(16'hDEE0 + 16'(i), 8'hC0 + 8'(i), "calibration");
      user_mode <= 1'b0;
      rd_chk(16'hDEE2, 8'h00, "calibration hidden");
   endtask
   // ram, stack top and sector 1 of program memory, enabled then locked
   task automatic t_memory;
      axi_wr(ca(16'h0080), 8'h12);
      axi_wr(ca(16'h00FF), 8'h34);
      rd_chk(16'h0080, 8'h12, "ram low");
      rd_chk(16'h00FF, 8'h34, "stack top");
      axi_wr(ADDR_CTRL, 8'h01);
      axi_wr(ca(16'hFC10), 8'h77);
      axi_wr(ca(16'hFEFF), 8'h66);
      rd_chk(16'hFC10, 8'h77, "program low");
      rd_chk(16'hFEFF, 8'h66, "sector 1 top");
      axi_wr(ADDR_CTRL, 8'h00);
      axi_wr(ca(16'hFC10), 8'h88);
      rd_chk(16'hFC10, 8'h77, "program locked");
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // main sequence after six cycles of reset; only t_reserved touches reserved space
   initial
   begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      t_reset_values();
      t_rw_regs();
      t_read_only();
      t_port();
      t_reserved();
      t_cal();
      t_memory();
      tally_and_finish();
   end
   // about ten times the expected run of some 250 cycles, so a stuck handshake ends it
   initial
   begin
      #20000;
      err_count++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
